// ### rtl/coulomb_counter.sv
// Purpose: Coulomb counter with blanking, bias, NV backup and temperature cell model.
// Assumes: Current and temperature inputs synchronous to mclk_i; NV memory answers with a load pulse.
// Notes: Registers reached over classic Wishbone; ack is registered, one wait state.
//
// Our own choices: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module coulomb_counter #(
  parameter int CONV_CYCLES = coulomb_pkg::CONV_CYCLES,
  parameter int SAVE_CONVS  = coulomb_pkg::SAVE_CONVS
) (
  // Clock and reset.
  input  wire logic        mclk_i,
  input  wire logic        rstn_i,
  // Wishbone slave.
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Converter and temperature.
  input  wire logic [15:0] cur_i,
  input  wire logic [7:0]  temp_i,
  output logic             offset_cal_o,
  // Nonvolatile parameter memory.
  input  wire logic        nv_load_i,
  input  wire logic [15:0] nv_count_i,
  input  wire logic [7:0]  nv_bias_i,
  output logic             nv_save_o,
  output logic      [15:0] nv_count_o
);
  localparam int ACC_W = 16 + coulomb_pkg::FRAC_W;

  typedef struct packed {
    logic [15:0]                    count;
    logic [coulomb_pkg::FRAC_W-1:0] frac;
    logic [7:0]                     hi_byte;
    logic [7:0]                     bias;
    logic                           discharge_blank_enable;
    logic [2:0][7:0]                tbp;
    logic [2:0][3:0][7:0]           slope;
    logic [15:0]                    full40;
    logic [9:0]                     ae40;
    logic [2:0][15:0]               cap;
    logic [31:0]                    conv_cnt;
    logic [15:0]                    save_cnt;
    logic                           skip;
    logic                           cal;
    logic                           save;
    coulomb_pkg::model_state_type   mst;
    logic signed [8:0]              deg;
    logic signed [8:0]              tgt;
    logic [2:0][17:0]               val;
    logic                           ack;
    logic [31:0]                    rdata;
  } state_type;

  state_type cur_ff;
  state_type nxt_ff;

  // Byte-lane merge for register writes.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      if (sel[b])
      begin
        r[8*b +: 8] = wd[8*b +: 8];
      end
    end
    return r;
  endfunction

  // Segment index (0 = segment one) of the degree interval ending at d.
  function automatic logic [1:0] seg_of(input logic signed [8:0] d, input logic [2:0][7:0] tbp);
    logic [1:0] s;
    s = 2'd0;
    if (d >= $signed({tbp[2][7], tbp[2]}))
      s = 2'd3;
    else if (d >= $signed({tbp[1][7], tbp[1]}))
      s = 2'd2;
    else if (d >= $signed({tbp[0][7], tbp[0]}))
      s = 2'd1;
    return s;
  endfunction

  // Clamp a model value to the range zero to one.
  function automatic logic [17:0] clip(input logic signed [18:0] v);
    logic [17:0] r;
    r = v[17:0];
    if (v < 0)
      r = 18'h0_0000;
    else if (v > $signed({1'b0, coulomb_pkg::ONE_FRAC}))
      r = coulomb_pkg::ONE_FRAC;
    return r;
  endfunction

  // Bus decode and accumulation helpers, shared with the assertions.
  logic                    req;
  logic                    wr;
  logic                    commit;
  logic                    conv_end;
  logic                    blank;
  logic signed [15:0]      cur_s;
  logic signed [ACC_W+1:0] sum;
  logic [15:0]             wr_count;

  assign req    = wb_cyc_i && wb_stb_i && !cur_ff.ack;
  assign wr     = req && wb_we_i;
  assign cur_s  = $signed(cur_i);
  assign conv_end = (cur_ff.conv_cnt == 32'(CONV_CYCLES - 1));
  // A low-byte lane write completes the count; a lone high lane only parks the byte.
  assign commit   = wr && (wb_adr_i == coulomb_pkg::OFS_COUNT) && wb_sel_i[0];
  assign wr_count = {wb_sel_i[1] ? wb_dat_i[15:8] : cur_ff.hi_byte, wb_dat_i[7:0]};

  // Blanking acts on the measured current only; the bias is added afterwards.
  always_comb
  begin
    blank = 1'b0;
    if (cur_s > 16'sh0000 && cur_s < coulomb_pkg::CHG_BLANK)
      blank = 1'b1;
    if (cur_ff.discharge_blank_enable && cur_s < 16'sh0000 && cur_s > -coulomb_pkg::DIS_BLANK)
      blank = 1'b1;
    sum = $signed({2'b00, cur_ff.count, cur_ff.frac})
        + $signed({{14{cur_s[15] && !blank}}, blank ? 16'h0000 : cur_i})
        + $signed({{22{cur_ff.bias[7]}}, cur_ff.bias});
  end

  // Next-state logic for the whole block.
  always_comb
  begin
    logic [33:0] prod;
    logic [1:0]  s;
    logic signed [8:0] d1;
    logic [31:0] mrg;
    mrg    = 32'h0000_0000;
    prod   = 34'h0_0000_0000;
    s      = 2'd0;
    d1     = 9'sh000;
    nxt_ff = cur_ff;
    nxt_ff.cal  = 1'b0;
    nxt_ff.save = 1'b0;
    nxt_ff.ack  = req;

    // Conversion timer; a count write restarts the conversion sequence.
    if (commit || conv_end)
      nxt_ff.conv_cnt = 32'h0000_0000;
    else
      nxt_ff.conv_cnt = cur_ff.conv_cnt + 32'h0000_0001;

    // Accumulation with saturation; the offset conversion after a write is skipped.
    if (conv_end)
    begin
      if (cur_ff.skip)
        nxt_ff.skip = 1'b0;
      else if (sum < 0)
        {nxt_ff.count, nxt_ff.frac} = '0;
      else if (sum[ACC_W+1:ACC_W] != 2'b00)
        {nxt_ff.count, nxt_ff.frac} = '1;
      else
        {nxt_ff.count, nxt_ff.frac} = sum[ACC_W-1:0];
      if (cur_ff.save_cnt == 16'(SAVE_CONVS - 1))
      begin
        nxt_ff.save_cnt = 16'h0000;
        nxt_ff.save     = 1'b1;
      end
      else
        nxt_ff.save_cnt = cur_ff.save_cnt + 16'h0001;
    end

    // Register writes.
    if (wr)
    begin
      case (wb_adr_i)
        coulomb_pkg::OFS_COUNT:
        begin
          if (wb_sel_i[1] && !wb_sel_i[0])
            nxt_ff.hi_byte = wb_dat_i[15:8];
          if (commit)
          begin
            nxt_ff.count = wr_count;
            nxt_ff.frac  = '0;
            nxt_ff.skip  = 1'b1;
            nxt_ff.cal   = 1'b1;
          end
        end
        coulomb_pkg::OFS_BIAS:
        begin
          mrg         = merge({24'h00_0000, cur_ff.bias}, wb_dat_i, wb_sel_i);
          nxt_ff.bias = mrg[7:0];
        end
        coulomb_pkg::OFS_CTRL:
        begin
          mrg         = merge({31'h0, cur_ff.discharge_blank_enable}, wb_dat_i, wb_sel_i);
          nxt_ff.discharge_blank_enable = mrg[0];
        end
        coulomb_pkg::OFS_TBP:
        begin
          mrg        = merge({8'h00, cur_ff.tbp}, wb_dat_i, wb_sel_i);
          nxt_ff.tbp = mrg[23:0];
        end
        coulomb_pkg::OFS_SLP_FU: nxt_ff.slope[0] = merge(cur_ff.slope[0], wb_dat_i, wb_sel_i);
        coulomb_pkg::OFS_SLP_AE: nxt_ff.slope[1] = merge(cur_ff.slope[1], wb_dat_i, wb_sel_i);
        coulomb_pkg::OFS_SLP_SE: nxt_ff.slope[2] = merge(cur_ff.slope[2], wb_dat_i, wb_sel_i);
        coulomb_pkg::OFS_FULL40:
        begin
          mrg           = merge({16'h0, cur_ff.full40}, wb_dat_i, wb_sel_i);
          nxt_ff.full40 = mrg[15:0];
        end
        coulomb_pkg::OFS_AE40:
        begin
          mrg         = merge({22'h0, cur_ff.ae40}, wb_dat_i, wb_sel_i);
          nxt_ff.ae40 = mrg[9:0];
        end
        default:                 nxt_ff.hi_byte = cur_ff.hi_byte;
      endcase
    end

    // Power-up restore from NV memory wins over everything else.
    if (nv_load_i)
    begin
      nxt_ff.count = nv_count_i;
      nxt_ff.frac  = '0;
      nxt_ff.bias  = nv_bias_i;
    end

    // Register reads; unmapped offsets read zero.
    nxt_ff.rdata = 32'h0000_0000;
    case (wb_adr_i)
      coulomb_pkg::OFS_COUNT:  nxt_ff.rdata = {16'h0000, cur_ff.count};
      coulomb_pkg::OFS_BIAS:   nxt_ff.rdata = {24'h00_0000, cur_ff.bias};
      coulomb_pkg::OFS_CTRL:   nxt_ff.rdata = {31'h0, cur_ff.discharge_blank_enable};
      coulomb_pkg::OFS_TBP:    nxt_ff.rdata = {8'h00, cur_ff.tbp};
      coulomb_pkg::OFS_SLP_FU: nxt_ff.rdata = cur_ff.slope[0];
      coulomb_pkg::OFS_SLP_AE: nxt_ff.rdata = cur_ff.slope[1];
      coulomb_pkg::OFS_SLP_SE: nxt_ff.rdata = cur_ff.slope[2];
      coulomb_pkg::OFS_FULL40: nxt_ff.rdata = {16'h0000, cur_ff.full40};
      coulomb_pkg::OFS_AE40:   nxt_ff.rdata = {22'h0, cur_ff.ae40};
      coulomb_pkg::OFS_CAP_FU: nxt_ff.rdata = {16'h0000, cur_ff.cap[0]};
      coulomb_pkg::OFS_CAP_AE: nxt_ff.rdata = {16'h0000, cur_ff.cap[1]};
      coulomb_pkg::OFS_CAP_SE: nxt_ff.rdata = {16'h0000, cur_ff.cap[2]};
      coulomb_pkg::OFS_STAT:   nxt_ff.rdata = {30'h0, cur_ff.mst != coulomb_pkg::M_IDLE, cur_ff.skip};
      default:                 nxt_ff.rdata = 32'h0000_0000;
    endcase

    // Cell model walk: one degree per clock from 40C down to the present temperature.
    case (cur_ff.mst)
      coulomb_pkg::M_IDLE:
      begin
        if (conv_end)
        begin
          nxt_ff.tgt    = $signed({temp_i[7], temp_i});
          nxt_ff.deg    = coulomb_pkg::TEMP_TOP;
          nxt_ff.val[0] = coulomb_pkg::ONE_FRAC;
          nxt_ff.val[1] = 18'({cur_ff.ae40, 4'h0});
          nxt_ff.val[2] = 18'h0_0000;
          nxt_ff.mst    = coulomb_pkg::M_WALK;
        end
      end
      coulomb_pkg::M_WALK:
      begin
        if (cur_ff.deg > cur_ff.tgt)
        begin
          d1 = cur_ff.deg - 9'sh001;
          s  = seg_of(d1, cur_ff.tbp);
          // Full shrinks when colder while both empty points rise.
          nxt_ff.val[0] = clip($signed({1'b0, cur_ff.val[0]}) - $signed({11'h0, cur_ff.slope[0][s]}));
          nxt_ff.val[1] = clip($signed({1'b0, cur_ff.val[1]}) + $signed({11'h0, cur_ff.slope[1][s]}));
          nxt_ff.val[2] = clip($signed({1'b0, cur_ff.val[2]}) + $signed({11'h0, cur_ff.slope[2][s]}));
          nxt_ff.deg    = d1;
        end
        else
          nxt_ff.mst = coulomb_pkg::M_DONE;
      end
      coulomb_pkg::M_DONE:
      begin
        for (int k = 0; k < 3; k++)
        begin
          prod = cur_ff.full40 * cur_ff.val[k];
          nxt_ff.cap[k] = prod[coulomb_pkg::PROD_LSB +: 16];
        end
        nxt_ff.mst = coulomb_pkg::M_IDLE;
      end
      default: nxt_ff.mst = coulomb_pkg::M_IDLE;
    endcase
  end

  // State register; all control state has a constant reset value.
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      cur_ff        <= '0;
      cur_ff.full40 <= coulomb_pkg::FULL40_RST;
      cur_ff.mst    <= coulomb_pkg::M_IDLE;
    end
    else
      cur_ff <= nxt_ff;
  end

  // Outputs straight from flip-flops.
  assign wb_ack_o     = cur_ff.ack;
  assign wb_dat_o     = cur_ff.rdata;
  assign offset_cal_o = cur_ff.cal;
  assign nv_save_o    = cur_ff.save;
  assign nv_count_o   = cur_ff.count;

  // Checks; the count path is only watched when no write or restore interferes.
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);

  logic quiet;
  assign quiet = conv_end && !cur_ff.skip && !commit && !nv_load_i;

  sequence s_commit;
    commit ##1 cur_ff.skip;
  endsequence

  sequence s_skip_end;
    conv_end && cur_ff.skip && !commit && !nv_load_i;
  endsequence

  a_charge_blank: assert property (quiet && cur_s > 0 && cur_s < coulomb_pkg::CHG_BLANK && cur_ff.bias == 8'h00
    |=> {cur_ff.count, cur_ff.frac} == $past({cur_ff.count, cur_ff.frac}))
    else $error("small charge current was accumulated");
  a_dis_blank: assert property (quiet && !cur_ff.discharge_blank_enable && cur_s < 0 && cur_ff.bias == 8'h00 && cur_ff.count != 16'h0
    |=> {cur_ff.count, cur_ff.frac} != $past({cur_ff.count, cur_ff.frac}))
    else $error("discharge blanked while blanking was off");
  a_bias_bypass: assert property (quiet && blank && cur_ff.count > 16'h0001 && cur_ff.count < 16'hFFFE
    |=> $signed({2'b00, cur_ff.count, cur_ff.frac}) == $past($signed({2'b00, cur_ff.count, cur_ff.frac})
      + $signed({{22{cur_ff.bias[7]}}, cur_ff.bias})))
    else $error("bias not added under blanking");
  a_sat_low: assert property (quiet && sum < 0 |=> cur_ff.count == 16'h0000 && cur_ff.frac == '0)
    else $error("count underflow not held at zero");
  a_sat_high: assert property (quiet && sum[ACC_W+1:ACC_W] == 2'b01 |=> cur_ff.count == 16'hFFFF)
    else $error("count overflow not held at maximum");
  a_write_clear: assert property (commit && !nv_load_i |=> cur_ff.frac == '0 && cur_ff.count == $past(wr_count))
    else $error("count write did not load value and clear fraction");
  a_cal_pulse: assert property (s_commit |-> offset_cal_o ##1 !offset_cal_o || $past(commit))
    else $error("offset correction not requested once");
  a_skip_once: assert property (s_skip_end |=> !cur_ff.skip && cur_ff.count == $past(cur_ff.count))
    else $error("first conversion after write was accumulated");
  a_nv_restore: assert property (nv_load_i |=> cur_ff.count == $past(nv_count_i) && cur_ff.bias == $past(nv_bias_i))
    else $error("restore did not load count and bias");
  a_model_flat: assert property (cur_ff.mst == coulomb_pkg::M_IDLE && conv_end && $signed(temp_i) >= 8'sd40
    |-> ##3 cur_ff.cap[0] == cur_ff.full40 && cur_ff.cap[2] == 16'h0000)
    else $error("curve not flat above 40C");
  a_model_step: assert property (cur_ff.mst == coulomb_pkg::M_WALK && cur_ff.deg > cur_ff.tgt
    |=> cur_ff.deg == $past(cur_ff.deg) - 9'sh001)
    else $error("model walk skipped a degree");
endmodule
`default_nettype wire

// ### rtl/coulomb_pkg.sv
// Purpose: Constants and register map for the coulomb counter and cell model.
// Assumes: 25 MHz clock, 32-bit classic Wishbone register access.
// Notes: Functional notes follow.
// Functional notes
// - Each conversion end adds the signed current result into the charge count.
// - Charge count spans zero to 409.6mVh in 6.25uVh steps, sixteen bits.
// - Hidden fraction bits sit below the count; software cannot reach them.
// - Accumulation saturates at the count maximum and at zero.
// - Positive current below 100uV is dropped before accumulation.
// - Any host write to the charge count clears the hidden fraction bits; a lone high-byte lane write only parks the byte and leaves them.
// - A count write requests an offset-correction conversion from the converter.
// - After a count write, accumulation restarts with the second following conversion.
// - Count is saved to nonvolatile memory periodically and restored at power-up.
// - The signed accumulation bias is added once per conversion cycle.
// - The accumulation bias is loaded from nonvolatile memory at power-up.
// - The accumulation bias bypasses current blanking.
// - Three curves, full, active empty and standby empty, of four segments.
// - Above 40C curves stay flat; segment four starts at 40C going colder.
// - Junction temperatures are 1C steps from -128C to +40C.
// - Segment slopes range zero to 15555ppm per degree in 61ppm steps.
// - Curves are rebuilt for the present temperature in whole-degree steps.
// - Points are normalised to full at 40C, held in 6.25uVh units.
// - Active empty at 40C is a 2^-10 fraction; standby empty there is zero.
// - Discharge below 25uV is blanked only while the blank enable is set.
// - Each conversion and accumulation step lasts 3.52s.
`default_nettype none
package coulomb_pkg;
  // Register byte offsets.
  localparam logic [7:0] OFS_COUNT  = 8'h00;
  localparam logic [7:0] OFS_BIAS   = 8'h04;
  localparam logic [7:0] OFS_CTRL   = 8'h08;
  localparam logic [7:0] OFS_TBP    = 8'h0C;
  localparam logic [7:0] OFS_SLP_FU = 8'h10;
  localparam logic [7:0] OFS_SLP_AE = 8'h14;
  localparam logic [7:0] OFS_SLP_SE = 8'h18;
  localparam logic [7:0] OFS_FULL40 = 8'h1C;
  localparam logic [7:0] OFS_AE40   = 8'h20;
  localparam logic [7:0] OFS_CAP_FU = 8'h24;
  localparam logic [7:0] OFS_CAP_AE = 8'h28;
  localparam logic [7:0] OFS_CAP_SE = 8'h2C;
  localparam logic [7:0] OFS_STAT   = 8'h30;
  // Accumulation: one current step per 3.52s is about 2^-12 of a count step.
  localparam int FRAC_W = 12;
  localparam logic signed [15:0] CHG_BLANK = 16'sh0040; // 100uV in 1.5625uV steps.
  localparam logic signed [15:0] DIS_BLANK = 16'sh0010; // 25uV in 1.5625uV steps.
  // Timing.
  localparam longint CLK_HZ       = 25000000;
  localparam longint CONV_TIME_MS = 3520;
  localparam int     CONV_CYCLES  = int'(CONV_TIME_MS * CLK_HZ / 1000);
  localparam int     SAVE_CONVS   = 16;
  // Cell model: normalised values in 2^-14 units, one slope step is about 61ppm.
  localparam logic [17:0]        ONE_FRAC = 18'h0_4000;
  localparam int                 AE_SHIFT = 4;
  localparam int                 PROD_LSB = 14;
  localparam logic signed [8:0]  TEMP_TOP = 9'sh028;
  localparam logic [15:0]        FULL40_RST = 16'h0000;
  typedef enum logic [1:0] {
    M_IDLE = 2'b00,
    M_WALK = 2'b01,
    M_DONE = 2'b10
  } model_state_type;
endpackage
`default_nettype wire

// ### tb/cell_partner.sv
// Purpose: Far-side model: current converter, temperature sensor and parameter NV memory.
// Assumes: One clock; the NV word survives a reset of the device.
// Notes: Released NV data lines show the inverse of the stored word.
`timescale 1ns/1ns
`default_nettype none
module cell_partner #(
  parameter logic [7:0] NV_BIAS = 8'h25
) (
  // Clock.
  input  wire logic        mclk_i,
  // Bench controls.
  input  wire logic [15:0] cur_set_i,
  input  wire logic [7:0]  temp_set_i,
  input  wire logic        load_req_i,
  // Device side.
  input  wire logic        offset_cal_i,
  input  wire logic        nv_save_i,
  input  wire logic [15:0] nv_count_i,
  output logic      [15:0] cur_o,
  output logic      [7:0]  temp_o,
  output logic             nv_load_o,
  output logic      [15:0] nv_count_o,
  output logic      [7:0]  nv_bias_o,
  output var int           saves_o,
  output var int           cals_o
);
  logic [15:0] mem;
  logic        req_q;

  // Everything starts known so the device never sees an undriven input.
  initial
  begin
    {cur_o, temp_o, nv_load_o, req_q, mem} = '0;
    saves_o = 0;
    cals_o = 0;
  end

  // Results change one cycle after the bench asks, like a fresh conversion result.
  always @(posedge mclk_i)
  begin
    cur_o <= cur_set_i;
    temp_o <= temp_set_i;
    req_q <= load_req_i;
    nv_load_o <= load_req_i && !req_q;
    if (nv_save_i)
    begin
      mem <= nv_count_i;
      saves_o <= saves_o + 1;
    end
    if (offset_cal_i)
      cals_o <= cals_o + 1;
  end

  // Outside a load the word is inverted, so a late sample cannot match by luck.
  assign nv_count_o = nv_load_o ? mem : ~mem;
  assign nv_bias_o  = nv_load_o ? NV_BIAS : ~NV_BIAS;
endmodule
`default_nettype wire

// ### tb/coulomb_counter_test.sv
// Purpose: Self-checking bench for the coulomb counter and cell model.
// Assumes: Conversion period shortened to 256 clocks, NV save every 2 conversions.
// Notes: Stimulus is placed mid-period so a few cycles of phase error do no harm.
`timescale 1ns/1ns
`default_nettype none
module coulomb_counter_test;
  localparam int         CONV    = 256;
  localparam logic [7:0] NV_BIAS = 8'h25;
  logic        mclk = 1'b0;
  logic        rstn = 1'b0;
  logic        wb_cyc = 1'b0;
  logic        wb_stb = 1'b0;
  logic        wb_we = 1'b0;
  logic [7:0]  wb_adr = 8'h00;
  logic [3:0]  wb_sel = 4'h0;
  logic [31:0] wb_wdat = 32'h0000_0000;
  logic [31:0] wb_rdat;
  logic        wb_ack;
  logic [15:0] cur_set = 16'h0000;
  logic [7:0]  temp_set = 8'h28;
  logic        load_req = 1'b0;
  logic [15:0] cur;
  logic [15:0] nv_cnt_in;
  logic [15:0] nv_cnt_out;
  logic [7:0]  temp;
  logic [7:0]  nv_bias_in;
  logic        cal;
  logic        nv_load;
  logic        nv_save;
  int          saves;
  int          cals;
  int          error_cnt = 0;
  int          samples_checked = 0;
  int          cyc_n = 0;
  int          base = 0;
  int          k = 0;
  int          commits = 0;
  int          temps[4] = '{40, 60, 15, -12};
  logic [31:0] exp_q[$];

  coulomb_counter #(.CONV_CYCLES(CONV), .SAVE_CONVS(2)) uut (
    .mclk_i(mclk), .rstn_i(rstn), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
    .cur_i(cur), .temp_i(temp), .offset_cal_o(cal), .nv_load_i(nv_load), .nv_count_i(nv_cnt_in),
    .nv_bias_i(nv_bias_in), .nv_save_o(nv_save), .nv_count_o(nv_cnt_out));

  cell_partner #(.NV_BIAS(NV_BIAS)) far (
    .mclk_i(mclk), .cur_set_i(cur_set), .temp_set_i(temp_set), .load_req_i(load_req),
    .offset_cal_i(cal), .nv_save_i(nv_save), .nv_count_i(nv_cnt_out), .cur_o(cur), .temp_o(temp),
    .nv_load_o(nv_load), .nv_count_o(nv_cnt_in), .nv_bias_o(nv_bias_in), .saves_o(saves), .cals_o(cals));

  // Clock at 25 MHz.
  always #20 mclk = ~mclk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("Mismatches %0d, comparisons %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // One classic cycle; the request holds until ack is sampled high.
  task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    {wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_wdat} <= {2'b11, w, a, s, d};
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (wb_ack !== 1'b1 && n < 50);
    if (n >= 50)
      check(32'h0000_0000, 32'h0000_0001);
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    exp_q.push_back({16'h0000, e});
    wb(1'b0, a, 4'hF, 32'h0000_0000);
  endtask

  // High byte parks first, low byte commits; the conversion phase restarts there.
  task automatic wcount(input logic [15:0] v);
    wb(1'b1, 8'h00, 4'b0010, {16'h0000, v[15:8], 8'h00});
    wb(1'b1, 8'h00, 4'b0001, {24'h00_0000, v[7:0]});
    commits++;
    base = cyc_n;
    k = 0;
  endtask

  // Present one current result and wait until the middle of the next period.
  task automatic step(input logic [15:0] c);
    cur_set <= c;
    k++;
    while (cyc_n < base + CONV / 2 + CONV * k)
      @(posedge mclk);
  endtask

  // Slope sum from 40 degrees down, with junctions at -10, 0 and 20 and slopes 1 to 4.
  function automatic int msum(input int t);
    int s;
    s = 0;
    for (int d = 40; d > t; d--)
      s += (d - 1 >= 20) ? 4 : (d - 1 >= 0) ? 3 : (d - 1 >= -10) ? 2 : 1;
    return s;
  endfunction

  // Every read answer is compared with the oldest note left by the driver.
  always @(posedge mclk)
  begin
    cyc_n <= cyc_n + 1;
    if (wb_ack === 1'b1 && wb_we === 1'b0)
      check(wb_rdat, exp_q.pop_front());
  end

  // Watchdog sized well above the roughly 9500 cycles the sequence needs.
  initial
  begin
    repeat (40000) @(posedge mclk);
    check(32'h0000_0000, 32'h0000_0001);
    end_of_test();
  end

  // Main sequence.
  initial
  begin
    int          t;
    logic [15:0] v;
    void'($urandom(66086));
    repeat (3) @(posedge mclk);
    rstn <= 1'b1;
    rd(8'h00, 16'h0000);
    rd(8'h04, 16'h0000);
    rd(8'h08, 16'h0000);
    rd(8'h3C, 16'h0000);
    wcount(16'h1234);
    rd(8'h00, 16'h1234);
    step(16'h4000);
    rd(8'h00, 16'h1234);
    step(16'h4000);
    rd(8'h00, 16'h1238);
    step(16'h0800);
    wcount(16'h0100);
    step(16'h0000);
    step(16'h0800);
    rd(8'h00, 16'h0100);
    step(16'h07C1);
    step(16'h003F);
    rd(8'h00, 16'h0100);
    step(16'h0040);
    rd(8'h00, 16'h0101);
    wb(1'b1, 8'h08, 4'hF, 32'h0000_0001);
    step(16'hFFFE);
    rd(8'h00, 16'h0101);
    step(16'hFFF0);
    rd(8'h00, 16'h0100);
    wb(1'b1, 8'h04, 4'hF, 32'h0000_000F);
    step(16'h0000);
    rd(8'h00, 16'h0101);
    wb(1'b1, 8'h08, 4'hF, 32'h0000_0000);
    wb(1'b1, 8'h04, 4'hF, 32'h0000_0000);
    step(16'hFFFF);
    rd(8'h00, 16'h0100);
    wcount(16'hFFFF);
    repeat (3) step(16'h7FFF);
    rd(8'h00, 16'hFFFF);
    wcount(16'h0003);
    repeat (2) step(16'h8000);
    rd(8'h00, 16'h0000);
    // A random count is saved, survives a reset in the NV model, and is restored.
    v = 16'($urandom_range(65535, 1));
    wcount(v);
    repeat (4) step(16'h0000);
    rstn <= 1'b0;
    repeat (3) @(posedge mclk);
    rstn <= 1'b1;
    rd(8'h00, 16'h0000);
    load_req <= 1'b1;
    repeat (3) @(posedge mclk);
    load_req <= 1'b0;
    rd(8'h00, v);
    rd(8'h04, {8'h00, NV_BIAS});
    check(32'(cals), 32'(commits));
    check(32'(saves != 0), 32'h0000_0001);
    // Cell model: full40 of 2^14 makes a capacity equal its normalised value.
    wb(1'b1, 8'h04, 4'hF, 32'h0000_0000);
    wb(1'b1, 8'h0C, 4'hF, 32'h0014_00F6);
    wb(1'b1, 8'h10, 4'hF, 32'h0000_0000);
    wb(1'b1, 8'h14, 4'hF, 32'h0403_0201);
    wb(1'b1, 8'h18, 4'hF, 32'h0403_0201);
    wb(1'b1, 8'h1C, 4'hF, 32'h0000_4000);
    wb(1'b1, 8'h20, 4'hF, 32'h0000_0100);
    wcount(16'h0000);
    for (int i = 0; i < 6; i++)
    begin
      t = (i < 4) ? temps[i] : int'($urandom_range(139, 0)) - 100;
      temp_set <= 8'(t);
      repeat (2) step(16'h0000);
      rd(8'h24, 16'h4000);
      rd(8'h28, 16'(4096 + msum(t)));
      rd(8'h2C, 16'(msum(t)));
    end
    wb(1'b1, 8'h24, 4'hF, 32'h0000_0000);
    rd(8'h24, 16'h4000);
    repeat (5) @(posedge mclk);
    end_of_test();
  end
endmodule
`default_nettype wire
